// [hw/i2c_link_pkg.sv]
// shared constants and types for both ends of the two-wire link
package i2c_link_pkg;

	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int BUS_FREE_NS = 1300;
	localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int FILTER_LEN = 3;
	localparam int STRAP_SETTLE_CYC = 2;

	// ---------------------------------------------
	// byte framing and addressing
	// ---------------------------------------------
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT_IDX = 4'h7;
	localparam logic [6:0] ADDR_BASE7 = 7'h48;
	localparam int SUB_SEL_MSB = 6;
	localparam int SUB_SEL_LSB = 3;
	localparam logic DIR_READ = 1'b1;

	// ---------------------------------------------
	// types
	// ---------------------------------------------
	typedef enum logic [1:0] {
		STRAP_VDD = 2'h0,
		STRAP_VSS = 2'h1,
		STRAP_SCL = 2'h2,
		STRAP_SDA = 2'h3
	} strap_e;

	typedef enum logic [2:0] {
		SL_IDLE = 3'h0,
		SL_RX = 3'h1,
		SL_ACK = 3'h3,
		SL_TX = 3'h2,
		SL_MACK = 3'h6
	} slv_state_e;

	typedef enum logic [1:0] {
		CMD_START = 2'h0,
		CMD_STOP = 2'h1,
		CMD_WRITE = 2'h2,
		CMD_READ = 2'h3
	} mcmd_e;

	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_START = 2'h1,
		M_BYTE = 2'h3,
		M_STOP = 2'h2
	} mst_state_e;

	// 7-bit own address from the two strap codes
	function automatic logic [6:0] strap_addr(input logic [1:0] up, input logic [1:0] lo);
		return ADDR_BASE7 + {3'h0, up, 2'h0} + {5'h0, lo};
	endfunction

endpackage

// [hw/i2c_link_if.sv]
// open-drain two-wire link joining the master end and the slave end
`timescale 1ns/10ps
interface i2c_link_if;
	logic scl_m_out;
	logic scl_m_oe;
	logic sda_m_out;
	logic sda_m_oe;
	logic scl_s_out;
	logic scl_s_oe;
	logic sda_s_out;
	logic sda_s_oe;
	logic scl;
	logic sda;

	// pulled-up wires: any enabled low driver wins
	assign scl = (scl_m_oe ? scl_m_out : 1'b1) & (scl_s_oe ? scl_s_out : 1'b1);
	assign sda = (sda_m_oe ? sda_m_out : 1'b1) & (sda_s_oe ? sda_s_out : 1'b1);

	modport master (output scl_m_out, scl_m_oe, sda_m_out, sda_m_oe, input scl, sda);
	modport slave (output scl_s_out, scl_s_oe, sda_s_out, sda_s_oe, input scl, sda);
endinterface

// [hw/i2c_slave_front.sv]
// slave end: start/stop detection, address match, byte ack and transmit
// Summary of operation
// - data stable while clock high
// - detect start and stop while clock high
// - only master makes start and stop
// - bus busy from start until after stop
// - eight bits, msb first, then ack slot
// - no limit on bytes per transfer
// - master clocks every acknowledge slot
// - acknowledger pulls low, sender releases line
// - acknowledge every accepted byte and address
// - master reader nacks last byte
// - nack bytes that cannot be accepted
// - first byte: address then direction bit
// - match address, ack, pick role
// - repeated start takes fresh address byte
// - master ends sequence with stop
// - two four-state straps select address
// - address lsb is the direction bit
// - byte after write address is subaddress
`timescale 1ns/10ps
module i2c_slave_front
	import i2c_link_pkg::*;
#(
	parameter int FILT_LEN = FILTER_LEN
) (
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	// link
	i2c_link_if.slave LINK,
	// address straps, sensed four-state codes
	input wire logic [1:0] ADDR_STRAP_UPPER_IN,
	input wire logic [1:0] ADDR_STRAP_LOWER_IN,
	// receive side
	input wire logic RX_ACCEPT_IN,
	output logic [7:0] RX_DATA_OUT,
	output logic RX_VALID_OUT,
	output logic [3:0] REG_SEL_OUT,
	output logic REG_SEL_VALID_OUT,
	// transmit side
	input wire logic [7:0] TX_DATA_IN,
	output logic TX_TAKEN_OUT,
	// status
	output logic BUS_BUSY_OUT,
	output logic SELECTED_OUT,
	output logic READ_MODE_OUT
);

	// ---------------------------------------------
	// line sampling
	// ---------------------------------------------
	logic [1:0] s1_q;
	logic [1:0] s2_q;
	logic [FILT_LEN-1:0] hist_q [2];
	logic [1:0] filt_q;
	logic [1:0] prev_q;
	logic scl_rise;
	logic scl_fall;
	logic sda_f;
	logic start_det;
	logic stop_det;

	function automatic logic all_eq(input logic [FILT_LEN-1:0] h, input logic v);
		return &(h ~^ {FILT_LEN{v}});
	endfunction

	// bit 1 is the clock line, bit 0 the data line; both idle high
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
		end else begin
			s1_q <= {LINK.scl, LINK.sda};
			s2_q <= s1_q;
		end
	end

	// a level must hold for the full window before it is believed
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			hist_q[0] <= '1;
			hist_q[1] <= '1;
			filt_q <= 2'h3;
			prev_q <= 2'h3;
		end else begin
			prev_q <= filt_q;
			for (int i = 0; i < 2; i++) begin
				hist_q[i] <= {hist_q[i][FILT_LEN-2:0], s2_q[i]};
				if (all_eq(hist_q[i], 1'b1)) begin
					filt_q[i] <= 1'b1;
				end else if (all_eq(hist_q[i], 1'b0)) begin
					filt_q[i] <= 1'b0;
				end
			end
		end
	end

	assign sda_f = filt_q[0];
	assign scl_rise = filt_q[1] & ~prev_q[1];
	assign scl_fall = ~filt_q[1] & prev_q[1];
	assign start_det = filt_q[1] & prev_q[1] & prev_q[0] & ~filt_q[0];
	assign stop_det = filt_q[1] & prev_q[1] & ~prev_q[0] & filt_q[0];

	// ---------------------------------------------
	// strap latch
	// ---------------------------------------------
	logic [1:0] up1_q;
	logic [1:0] up2_q;
	logic [1:0] lo1_q;
	logic [1:0] lo2_q;
	logic [1:0] settle_q;
	logic [6:0] own_addr_q;

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			up1_q <= STRAP_VDD;
			up2_q <= STRAP_VDD;
			lo1_q <= STRAP_VDD;
			lo2_q <= STRAP_VDD;
		end else begin
			up1_q <= ADDR_STRAP_UPPER_IN;
			up2_q <= up1_q;
			lo1_q <= ADDR_STRAP_LOWER_IN;
			lo2_q <= lo1_q;
		end
	end

	// straps are caught once, after the synchronisers have filled
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			settle_q <= 2'h0;
			own_addr_q <= ADDR_BASE7;
		end else if (settle_q != 2'(STRAP_SETTLE_CYC + 1)) begin
			settle_q <= settle_q + 2'h1;
			if (settle_q == 2'(STRAP_SETTLE_CYC)) begin
				own_addr_q <= strap_addr(up2_q, lo2_q);
			end
		end
	end

	// ---------------------------------------------
	// bus busy
	// ---------------------------------------------
	localparam int FREE_W = $clog2(BUS_FREE_CYC + 1);
	logic [FREE_W-1:0] free_cnt_q;
	logic busy_q;

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			busy_q <= 1'b0;
			free_cnt_q <= '0;
		end else if (start_det) begin
			busy_q <= 1'b1;
			free_cnt_q <= '0;
		end else if (stop_det) begin
			free_cnt_q <= FREE_W'(BUS_FREE_CYC);
		end else if (free_cnt_q != '0) begin
			free_cnt_q <= free_cnt_q - 1'b1;
			if (free_cnt_q == FREE_W'(1)) begin
				busy_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------
	// byte engine
	// ---------------------------------------------
	slv_state_e state_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic first_q;
	logic sub_q;
	logic rd_q;
	logic ack_q;
	logic sda_oe_q;
	logic sel_q;
	logic [7:0] rx_data_q;
	logic rx_valid_q;
	logic [3:0] reg_sel_q;
	logic reg_sel_valid_q;
	logic tx_taken_q;
	logic accept;

	// subaddress is always taken; data only when the user can take it
	assign accept = sub_q | RX_ACCEPT_IN;

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_q <= SL_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			first_q <= 1'b0;
			sub_q <= 1'b0;
			rd_q <= 1'b0;
			ack_q <= 1'b0;
			sda_oe_q <= 1'b0;
			sel_q <= 1'b0;
			rx_data_q <= 8'h00;
			rx_valid_q <= 1'b0;
			reg_sel_q <= 4'h0;
			reg_sel_valid_q <= 1'b0;
			tx_taken_q <= 1'b0;
		end else begin
			rx_valid_q <= 1'b0;
			reg_sel_valid_q <= 1'b0;
			tx_taken_q <= 1'b0;
			if (start_det) begin
				state_q <= SL_RX;
				cnt_q <= 4'h0;
				first_q <= 1'b1;
				sda_oe_q <= 1'b0;
				sel_q <= 1'b0;
			end else if (stop_det) begin
				state_q <= SL_IDLE;
				sda_oe_q <= 1'b0;
				sel_q <= 1'b0;
			end else begin
				case (state_q)
					SL_RX: begin
						if (scl_rise) begin
							sh_q <= {sh_q[6:0], sda_f};
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall && cnt_q == BYTE_BITS) begin
							first_q <= 1'b0;
							cnt_q <= 4'h0;
							if (first_q) begin
								if (sh_q[7:1] == own_addr_q) begin
									sda_oe_q <= 1'b1;
									ack_q <= 1'b1;
									rd_q <= (sh_q[0] == DIR_READ);
									sub_q <= (sh_q[0] != DIR_READ);
									sel_q <= 1'b1;
									state_q <= SL_ACK;
								end else begin
									state_q <= SL_IDLE;
								end
							end else begin
								sda_oe_q <= accept;
								ack_q <= accept;
								state_q <= SL_ACK;
								if (accept && sub_q) begin
									reg_sel_q <= sh_q[SUB_SEL_MSB:SUB_SEL_LSB];
									reg_sel_valid_q <= 1'b1;
									sub_q <= 1'b0;
								end else if (accept) begin
									rx_data_q <= sh_q;
									rx_valid_q <= 1'b1;
								end
							end
						end
					end
					SL_ACK: begin
						// the master's clock ends the slot
						if (scl_fall) begin
							sda_oe_q <= 1'b0;
							cnt_q <= 4'h0;
							if (!ack_q) begin
								state_q <= SL_IDLE;
							end else if (rd_q) begin
								sh_q <= TX_DATA_IN;
								tx_taken_q <= 1'b1;
								sda_oe_q <= ~TX_DATA_IN[7];
								state_q <= SL_TX;
							end else begin
								state_q <= SL_RX;
							end
						end
					end
					SL_TX: begin
						// bits change only after a falling clock edge
						if (scl_fall) begin
							if (cnt_q == LAST_BIT_IDX) begin
								sda_oe_q <= 1'b0;
								state_q <= SL_MACK;
							end else begin
								sda_oe_q <= ~sh_q[6];
								sh_q <= {sh_q[6:0], 1'b0};
								cnt_q <= cnt_q + 4'h1;
							end
						end
					end
					SL_MACK: begin
						if (scl_rise) begin
							ack_q <= ~sda_f;
						end else if (scl_fall) begin
							cnt_q <= 4'h0;
							if (ack_q) begin
								sh_q <= TX_DATA_IN;
								tx_taken_q <= 1'b1;
								sda_oe_q <= ~TX_DATA_IN[7];
								state_q <= SL_TX;
							end else begin
								state_q <= SL_IDLE;
							end
						end
					end
					default: begin
						state_q <= SL_IDLE;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	// slave never drives the clock; no stretching
	assign LINK.scl_s_out = 1'b0;
	assign LINK.scl_s_oe = 1'b0;
	assign LINK.sda_s_out = 1'b0;
	assign LINK.sda_s_oe = sda_oe_q;
	assign RX_DATA_OUT = rx_data_q;
	assign RX_VALID_OUT = rx_valid_q;
	assign REG_SEL_OUT = reg_sel_q;
	assign REG_SEL_VALID_OUT = reg_sel_valid_q;
	assign TX_TAKEN_OUT = tx_taken_q;
	assign BUS_BUSY_OUT = busy_q;
	assign SELECTED_OUT = sel_q;
	assign READ_MODE_OUT = rd_q;

endmodule

// [hw/i2c_master_end.sv]
// master end: clock divider, start/stop generation and byte transfers
`timescale 1ns/10ps
module i2c_master_end
	import i2c_link_pkg::*;
#(
	parameter int QUARTER_CYC = SCL_QUARTER_CYC
) (
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	// link
	i2c_link_if.master LINK,
	// command
	input wire logic CMD_VALID_IN,
	input wire logic [1:0] CMD_IN,
	input wire logic [7:0] CMD_DATA_IN,
	input wire logic CMD_NACK_IN,
	output logic CMD_READY_OUT,
	// result
	output logic RES_VALID_OUT,
	output logic [7:0] RES_DATA_OUT,
	output logic RES_ACK_OUT,
	// status
	output logic BUS_BUSY_OUT
);

	// ---------------------------------------------
	// quarter-bit tick and data sampling
	// ---------------------------------------------
	localparam int QW = $clog2(QUARTER_CYC + 1);
	logic [QW-1:0] qcnt_q;
	logic tick_q;
	logic sda1_q;
	logic sda2_q;

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			qcnt_q <= '0;
			tick_q <= 1'b0;
		end else if (qcnt_q == QW'(QUARTER_CYC - 1)) begin
			qcnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			qcnt_q <= qcnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sda1_q <= 1'b1;
			sda2_q <= 1'b1;
		end else begin
			sda1_q <= LINK.sda;
			sda2_q <= sda1_q;
		end
	end

	// ---------------------------------------------
	// sequencer: four quarters per bit or condition
	// ---------------------------------------------
	mst_state_e state_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic rd_q;
	logic nack_q;
	logic ack_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic ready_q;
	logic res_valid_q;
	logic busy_q;

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_q <= M_IDLE;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rd_q <= 1'b0;
			nack_q <= 1'b0;
			ack_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			ready_q <= 1'b1;
			res_valid_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			res_valid_q <= 1'b0;
			case (state_q)
				M_IDLE: begin
					if (CMD_VALID_IN) begin
						ready_q <= 1'b0;
						ph_q <= 2'h0;
						bit_q <= 4'h0;
						sh_q <= CMD_DATA_IN;
						rd_q <= (CMD_IN == CMD_READ);
						nack_q <= CMD_NACK_IN;
						case (CMD_IN)
							CMD_START: state_q <= M_START;
							CMD_STOP: state_q <= M_STOP;
							default: state_q <= M_BYTE;
						endcase
					end
				end
				M_START: begin
					if (tick_q) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: sda_oe_q <= 1'b0;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: begin
								sda_oe_q <= 1'b1;
								busy_q <= 1'b1;
							end
							default: begin
								scl_oe_q <= 1'b1;
								ready_q <= 1'b1;
								state_q <= M_IDLE;
							end
						endcase
					end
				end
				M_STOP: begin
					if (tick_q) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: sda_oe_q <= 1'b1;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: begin
								sda_oe_q <= 1'b0;
								busy_q <= 1'b0;
							end
							default: begin
								ready_q <= 1'b1;
								state_q <= M_IDLE;
							end
						endcase
					end
				end
				M_BYTE: begin
					if (tick_q) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: begin
								// data moves only while the clock is low
								if (bit_q < BYTE_BITS) begin
									sda_oe_q <= ~rd_q & ~sh_q[7];
								end else begin
									sda_oe_q <= rd_q & ~nack_q;
								end
							end
							2'h1: scl_oe_q <= 1'b0;
							2'h2: begin
								if (bit_q < BYTE_BITS) begin
									sh_q <= {sh_q[6:0], sda2_q};
								end else begin
									ack_q <= rd_q | ~sda2_q;
								end
							end
							default: begin
								scl_oe_q <= 1'b1;
								if (bit_q == BYTE_BITS) begin
									sda_oe_q <= 1'b0;
									res_valid_q <= 1'b1;
									ready_q <= 1'b1;
									state_q <= M_IDLE;
								end else begin
									bit_q <= bit_q + 4'h1;
								end
							end
						endcase
					end
				end
				default: begin
					state_q <= M_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign LINK.scl_m_out = 1'b0;
	assign LINK.scl_m_oe = scl_oe_q;
	assign LINK.sda_m_out = 1'b0;
	assign LINK.sda_m_oe = sda_oe_q;
	assign CMD_READY_OUT = ready_q;
	assign RES_VALID_OUT = res_valid_q;
	assign RES_DATA_OUT = sh_q;
	assign RES_ACK_OUT = ack_q;
	assign BUS_BUSY_OUT = busy_q;

endmodule

// [verif/i2c_link_sva.sv]
// assertions on the open-drain link between the master end and the slave end
`timescale 1ns/10ps
module i2c_link_sva (
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	// link
	input wire logic scl_m_oe,
	input wire logic sda_m_oe,
	input wire logic scl_s_oe,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (RST_IN);

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	logic [3:0] rise_cnt_q;

	sequence start_s;
		scl && $past(scl) && $fell(sda);
	endsequence

	sequence stop_s;
		scl && $past(scl) && $rose(sda);
	endsequence

	// scl rises since the last start, saturating
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			rise_cnt_q <= 4'h0;
		end else if (scl && $past(scl) && $fell(sda)) begin
			rise_cnt_q <= 4'h0;
		end else if ($rose(scl) && rise_cnt_q != 4'hf) begin
			rise_cnt_q <= rise_cnt_q + 4'h1;
		end
	end

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	slave_no_clock_a: assert property (!scl_s_oe)
		else $error("slave pulled the clock line");
	sda_steady_a: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("slave moved data while clock high");
	no_clash_a: assert property (scl |-> !(sda_s_oe && sda_m_oe))
		else $error("both ends pull data during a clock pulse");
	// slack of 10 covers sync plus filter delay after the clock fall
	answer_time_a: assert property ($changed(sda_s_oe) |-> $past(scl, 10))
		else $error("slave data change too long after clock fall");
	// high time is two quarters of 8 cycles in this bench
	scl_pulse_a: assert property ($rose(scl) |=> scl [*8])
		else $error("clock pulse too short");
	start_hold_a: assert property (start_s |=> scl [*4])
		else $error("clock fell right after start");
	bus_free_a: assert property (stop_s |=> (scl && sda) [*6])
		else $error("bus reused too soon after stop");
	addr_quiet_a: assert property ($rose(scl) && rise_cnt_q < 4'h8 |-> !sda_s_oe)
		else $error("slave drove data inside the address byte");

	cover property (start_s);
	cover property ($rose(sda_s_oe));
	cover property (stop_s);
	cover property (scl && sda_s_oe && rise_cnt_q > 4'h9);
endmodule

// [verif/test_i2c_slave_addressing_front_end.sv]
// self-checking bench: master end and slave end joined over the link
`timescale 1ns/10ps
module test_i2c_slave_addressing_front_end;
	import i2c_link_pkg::*;
	localparam int QC = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic [1:0] cmd = 2'h0;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_nack = 1'b0;
	logic [1:0] strap_up = 2'h0;
	logic [1:0] strap_lo = 2'h0;
	logic rx_accept = 1'b1;
	logic [7:0] tx_data = 8'hc3;
	logic [7:0] rx_data, res_data, last_rx, last_sel;
	logic [3:0] reg_sel;
	logic rx_valid, reg_sel_valid, tx_taken, s_busy, selected, read_mode;
	logic m_ready, res_valid, res_ack, m_busy;
	int rx_cnt = 0;
	int sel_cnt = 0;
	int tx_cnt = 0;
	int res_cnt = 0;
	int fail_count = 0;
	int checks_done = 0;

	always #5 clk = ~clk;

	// ---------------------------------------------
	// design and checker
	// ---------------------------------------------
	i2c_link_if link();
	i2c_slave_front i2c_slave_front_inst (.SYS_CLK_IN(clk), .RST_IN(rst), .LINK(link),
		.ADDR_STRAP_UPPER_IN(strap_up), .ADDR_STRAP_LOWER_IN(strap_lo),
		.RX_ACCEPT_IN(rx_accept), .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid),
		.REG_SEL_OUT(reg_sel), .REG_SEL_VALID_OUT(reg_sel_valid), .TX_DATA_IN(tx_data),
		.TX_TAKEN_OUT(tx_taken), .BUS_BUSY_OUT(s_busy), .SELECTED_OUT(selected),
		.READ_MODE_OUT(read_mode));
	i2c_master_end #(.QUARTER_CYC(QC)) i2c_master_end_inst (.SYS_CLK_IN(clk), .RST_IN(rst),
		.LINK(link), .CMD_VALID_IN(cmd_valid), .CMD_IN(cmd), .CMD_DATA_IN(cmd_data),
		.CMD_NACK_IN(cmd_nack), .CMD_READY_OUT(m_ready), .RES_VALID_OUT(res_valid),
		.RES_DATA_OUT(res_data), .RES_ACK_OUT(res_ack), .BUS_BUSY_OUT(m_busy));
	i2c_link_sva i2c_link_sva_inst (.SYS_CLK_IN(clk), .RST_IN(rst),
		.scl_m_oe(link.scl_m_oe), .sda_m_oe(link.sda_m_oe), .scl_s_oe(link.scl_s_oe),
		.sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));

	// user-side monitor; next tx byte is offered once the current one is taken
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			last_rx <= rx_data;
			rx_cnt <= rx_cnt + 1;
		end
		if (reg_sel_valid === 1'b1) begin
			last_sel <= {4'h0, reg_sel};
			sel_cnt <= sel_cnt + 1;
		end
		if (tx_taken === 1'b1) begin
			tx_data <= tx_data + 8'h11;
			tx_cnt <= tx_cnt + 1;
		end
		if (res_valid === 1'b1) begin
			res_cnt <= res_cnt + 1;
		end
	end

	// ---------------------------------------------
	// shared tasks
	// ---------------------------------------------
	task automatic wrap_up;
		$display("checks_done %0d fail_count %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic chk1(input logic seen, input logic exp);
		check({7'h0, seen}, {7'h0, exp});
	endtask

	task automatic do_reset(input logic [1:0] up, input logic [1:0] lo);
		@(posedge clk);
		rst <= 1'b1;
		strap_up <= up;
		strap_lo <= lo;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	// one master command; valid for one clock, then wait for ready
	task automatic do_cmd(input logic [1:0] c, input logic [7:0] d, input logic nk);
		int n;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		cmd_data <= d;
		cmd_nack <= nk;
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (m_ready !== 1'b1 && n < 400);
		if (m_ready !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t: master never ready", $time);
			wrap_up();
		end
	endtask

	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic write_flow;
		logic [7:0] d;
		do_reset(2'h0, 2'h0);
		do_cmd(CMD_START, 8'h00, 1'b0);
		do_cmd(CMD_WRITE, 8'h90, 1'b0);
		chk1(res_ack, 1'b1);
		chk1(selected, 1'b1);
		chk1(read_mode, 1'b0);
		chk1(s_busy, 1'b1);
		do_cmd(CMD_WRITE, 8'had, 1'b0);
		check(last_sel, 8'h05);
		check(8'(sel_cnt), 8'h01);
		for (int i = 0; i < 3; i++) begin
			d = 8'h81 + 8'(i * 37);
			do_cmd(CMD_WRITE, d, 1'b0);
			chk1(res_ack, 1'b1);
			check(last_rx, d);
		end
		check(8'(rx_cnt), 8'h03);
		@(posedge clk);
		rx_accept <= 1'b0;
		do_cmd(CMD_WRITE, 8'h5a, 1'b0);
		chk1(res_ack, 1'b0);
		@(posedge clk);
		rx_accept <= 1'b1;
		do_cmd(CMD_WRITE, 8'h66, 1'b0);
		chk1(res_ack, 1'b0);
		do_cmd(CMD_STOP, 8'h00, 1'b0);
		chk1(m_busy, 1'b0);
		repeat (4) @(negedge clk);
		chk1(selected, 1'b0);
		chk1(s_busy, 1'b1);
		repeat (BUS_FREE_CYC) @(negedge clk);
		chk1(s_busy, 1'b0);
		check(8'(res_cnt), 8'h07);
	endtask

	task automatic mismatch_flow;
		do_cmd(CMD_START, 8'h00, 1'b0);
		do_cmd(CMD_WRITE, 8'h92, 1'b0);
		chk1(res_ack, 1'b0);
		chk1(selected, 1'b0);
		do_cmd(CMD_WRITE, 8'h90, 1'b0);
		chk1(res_ack, 1'b0);
		do_cmd(CMD_START, 8'h00, 1'b0);
		do_cmd(CMD_WRITE, 8'h90, 1'b0);
		chk1(res_ack, 1'b1);
		do_cmd(CMD_STOP, 8'h00, 1'b0);
	endtask

	task automatic read_flow;
		do_cmd(CMD_START, 8'h00, 1'b0);
		do_cmd(CMD_WRITE, 8'h90, 1'b0);
		do_cmd(CMD_WRITE, 8'h18, 1'b0);
		check(last_sel, 8'h03);
		do_cmd(CMD_START, 8'h00, 1'b0);
		do_cmd(CMD_WRITE, 8'h91, 1'b0);
		chk1(res_ack, 1'b1);
		chk1(read_mode, 1'b1);
		for (int i = 0; i < 3; i++) begin
			do_cmd(CMD_READ, 8'h00, i == 2);
			check(res_data, 8'hc3 + 8'(i * 17));
		end
		do_cmd(CMD_STOP, 8'h00, 1'b0);
		check(8'(tx_cnt), 8'h03);
	endtask

	task automatic strap_flow;
		logic [7:0] a;
		for (int k = 0; k < 4; k++) begin
			do_reset(2'(k), 2'(3 - k));
			a = 8'h90 + 8'(8 * k) + 8'(2 * (3 - k));
			do_cmd(CMD_START, 8'h00, 1'b0);
			do_cmd(CMD_WRITE, a, 1'b0);
			chk1(res_ack, 1'b1);
			@(posedge clk);
			strap_up <= 2'(k + 1);
			do_cmd(CMD_START, 8'h00, 1'b0);
			do_cmd(CMD_WRITE, a, 1'b0);
			chk1(res_ack, 1'b1);
			do_cmd(CMD_STOP, 8'h00, 1'b0);
		end
	endtask

	initial begin
		write_flow();
		mismatch_flow();
		read_flow();
		strap_flow();
		wrap_up();
	end
endmodule
